// [rtl/ccuod_pkg.sv]
package ccuod_pkg;

  // processor cycle against the 25 MHz system clock
  localparam int PROC_CYCLE_NS = 200;
  localparam int CLK_PERIOD_NS = 40;
  // a least time, so round up
  localparam int CLK_PER_PCYC = (PROC_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // minimum processor cycles per instruction
  localparam int MIN_BAL = 4;
  localparam int MIN_LA = 1;
  localparam int MIN_INOUT = 1;
  localparam int MIN_IOH = 7;
  localparam int MIN_ADAPTER_REG_XFER_IMM = 6;
  localparam int MIN_IC = 3;
  localparam int MIN_STC = 1;
  localparam int MIN_ICT = 4;
  localparam int MIN_STCT = 3;
  localparam int MIN_LCR = 1;
  localparam int MIN_BB = 2;
  localparam int MAX_LEN = MIN_IOH * CLK_PER_PCYC;

  // opcode fields
  localparam logic [4:0] OPH_ADDR20 = 5'h17;
  localparam logic [1:0] OPH_BB = 2'h3;
  localparam logic [1:0] SUB_BAL = 2'h1;
  localparam logic [1:0] SUB_LA = 2'h0;
  localparam logic [7:0] OPL_IOH = 8'h50;
  localparam logic [7:0] OPL_ADAPTER_REG_XFER_IMM = 8'h70;
  localparam logic [7:0] OPL_LCR = 8'h08;
  localparam logic [7:0] OPL_ICT = 8'h10;
  localparam logic [7:0] OPL_STCT = 8'h20;

  // software register map
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_CTRL = 4'h9;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic [23:0] GR_RST = 24'h000000;
  localparam int ST_CLS_LSB = 0;
  localparam int ST_Z_BIT = 4;
  localparam int ST_C_BIT = 5;
  localparam int ST_BUSY_BIT = 6;

  typedef enum logic [3:0] {
    CLS_NONE, CLS_BAL, CLS_LA, CLS_IN, CLS_OUT, CLS_IOH, CLS_ADAPTER_REG_XFER_IMM,
    CLS_IC, CLS_STC, CLS_ICT, CLS_STCT, CLS_LCR, CLS_BB
  } ccuod_cls_e;

  typedef enum logic {
    ST_IDLE, ST_EXEC
  } ccuod_state_e;

endpackage

// [rtl/ccuod_reg_sel.sv]
`timescale 1ns/1ps
module ccuod_reg_sel (
  input wire logic [2:0] fld_in,
  input wire logic two_bit_in,
  output logic [2:0] idx_out
);

  // short fields only reach odd registers
  assign idx_out = two_bit_in ? {fld_in[2:1], 1'b1} : fld_in;

endmodule

// [rtl/ccuod_decoder.sv]
`timescale 1ns/1ps
module ccuod_decoder #(
  parameter int CNT_W = 6
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_hw0_in,
  input wire logic [15:0] instr_hw1_in,
  output logic instr_ready_out,
  output logic done_out,
  output logic branch_out,
  output logic [19:0] branch_addr_out,
  output logic cond_c_out,
  output logic cond_z_out,
  output logic stor_req_out,
  output logic stor_wr_out,
  output logic [19:0] stor_addr_out,
  output logic [7:0] stor_wdata_out,
  input wire logic [7:0] stor_rdata_in,
  output logic ext_req_out,
  output logic ext_wr_out,
  output logic [6:0] ext_addr_out,
  output logic [23:0] ext_wdata_out,
  input wire logic [23:0] ext_rdata_in,
  output logic adp_req_out,
  output logic [15:0] adp_addr_out,
  output logic [15:0] adp_wdata_out,
  input wire logic adp_ack_in,
  input wire logic [15:0] adp_rdata_in,
  input wire logic [3:0] sw_addr_in,
  input wire logic [31:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [31:0] sw_rdata_out
);

  if ((1 << CNT_W) <= ccuod_pkg::MAX_LEN)
  begin : g_cnt_chk
    $error("CNT_W too small for the longest instruction");
  end

  function automatic logic [7:0] get_byte(input logic [23:0] w, input logic n);
    get_byte = n ? w[7:0] : w[15:8];
  endfunction

  function automatic logic [23:0] put_byte(input logic [23:0] w, input logic n,
                                           input logic [7:0] b);
    put_byte = n ? {w[23:8], b} : {w[23:16], b, w[7:0]};
  endfunction

  ccuod_pkg::ccuod_state_e state_r;
  ccuod_pkg::ccuod_cls_e dec_cls;
  ccuod_pkg::ccuod_cls_e cls_r;
  logic [23:0] gr_r [8];
  logic ctrl_en_r;
  logic [CNT_W-1:0] cnt_r;
  logic [2:0] ra_idx;
  logic [2:0] rb_idx;
  logic [2:0] ra_r;
  logic [2:0] rb_r;
  logic na_r;
  logic nb_r;
  logic two_a;
  logic two_b;
  logic [23:0] va;
  logic [23:0] vb;
  logic [15:0] vb_lo;
  logic [6:0] disp;
  logic [19:0] ea_calc;
  logic [19:0] rel_tgt;
  logic [19:0] imm20;
  logic [6:0] dec_e;
  logic [2:0] mask;
  logic [7:0] tst_byte;
  logic bit_hit;
  logic bit_r;
  logic [19:0] tgt_r;
  logic [3:0] min_pc;
  logic upd_flag;
  logic upd_r;
  logic is_stor;
  logic is_ext;
  logic is_adp;
  logic accept;
  logic fin;
  logic stor_cap_r;
  logic ext_cap_r;
  logic [7:0] stor_data_r;
  logic [23:0] ext_data_r;
  logic [15:0] adp_data_r;
  logic [7:0] res_byte;
  logic [15:0] res_val;

  // opcode classes; unknown patterns fall to CLS_NONE and run one processor cycle
  always_comb
  begin
    dec_cls = ccuod_pkg::CLS_NONE;
    if (instr_hw0_in[15:11] == ccuod_pkg::OPH_ADDR20)
    begin
      if (instr_hw0_in[7:6] == ccuod_pkg::SUB_BAL)
        dec_cls = ccuod_pkg::CLS_BAL;
      else if (instr_hw0_in[7:6] == ccuod_pkg::SUB_LA)
        dec_cls = ccuod_pkg::CLS_LA;
    end
    else if (instr_hw0_in[15:14] == ccuod_pkg::OPH_BB && instr_hw0_in[11])
      dec_cls = ccuod_pkg::CLS_BB;
    else if (!instr_hw0_in[15])
    begin
      if (instr_hw0_in[11])
        dec_cls = instr_hw0_in[7] ? ccuod_pkg::CLS_STC : ccuod_pkg::CLS_IC;
      else if (instr_hw0_in[7:0] == ccuod_pkg::OPL_IOH)
        dec_cls = ccuod_pkg::CLS_IOH;
      else if (instr_hw0_in[7:0] == ccuod_pkg::OPL_ADAPTER_REG_XFER_IMM && instr_hw0_in[14:12] == 3'h0)
        dec_cls = ccuod_pkg::CLS_ADAPTER_REG_XFER_IMM;
      else if (instr_hw0_in[7:0] == ccuod_pkg::OPL_LCR)
        dec_cls = ccuod_pkg::CLS_LCR;
      else if (instr_hw0_in[7:0] == ccuod_pkg::OPL_ICT)
        dec_cls = ccuod_pkg::CLS_ICT;
      else if (instr_hw0_in[7:0] == ccuod_pkg::OPL_STCT)
        dec_cls = ccuod_pkg::CLS_STCT;
      else if (instr_hw0_in[7] && instr_hw0_in[1:0] == 2'h0)
        dec_cls = instr_hw0_in[2] ? ccuod_pkg::CLS_OUT : ccuod_pkg::CLS_IN;
    end
  end

  // per-class width of register fields, timing and latch flag
  always_comb
  begin
    two_a = 1'b0;
    two_b = 1'b0;
    min_pc = 4'h1;
    upd_flag = 1'b0;
    case (dec_cls)
      ccuod_pkg::CLS_BAL: min_pc = 4'(ccuod_pkg::MIN_BAL);
      ccuod_pkg::CLS_LA: min_pc = 4'(ccuod_pkg::MIN_LA);
      ccuod_pkg::CLS_IN, ccuod_pkg::CLS_OUT: min_pc = 4'(ccuod_pkg::MIN_INOUT);
      ccuod_pkg::CLS_IOH:
      begin
        min_pc = 4'(ccuod_pkg::MIN_IOH);
        upd_flag = 1'b1;
      end
      ccuod_pkg::CLS_ADAPTER_REG_XFER_IMM:
      begin
        min_pc = 4'(ccuod_pkg::MIN_ADAPTER_REG_XFER_IMM);
        upd_flag = 1'b1;
      end
      ccuod_pkg::CLS_IC:
      begin
        two_a = 1'b1;
        min_pc = 4'(ccuod_pkg::MIN_IC);
        upd_flag = 1'b1;
      end
      ccuod_pkg::CLS_STC:
      begin
        two_a = 1'b1;
        min_pc = 4'(ccuod_pkg::MIN_STC);
      end
      ccuod_pkg::CLS_ICT:
      begin
        two_a = 1'b1;
        min_pc = 4'(ccuod_pkg::MIN_ICT);
      end
      ccuod_pkg::CLS_STCT:
      begin
        two_a = 1'b1;
        min_pc = 4'(ccuod_pkg::MIN_STCT);
      end
      ccuod_pkg::CLS_LCR:
      begin
        two_a = 1'b1;
        two_b = 1'b1;
        min_pc = 4'(ccuod_pkg::MIN_LCR);
        upd_flag = 1'b1;
      end
      ccuod_pkg::CLS_BB:
      begin
        two_a = 1'b1;
        min_pc = 4'(ccuod_pkg::MIN_BB);
      end
      default: min_pc = 4'h1;
    endcase
  end

  // operand a: bits 5-7, operand b / base: bits 1-3
  ccuod_reg_sel u_sel_a (
    .fld_in(instr_hw0_in[10:8]),
    .two_bit_in(two_a),
    .idx_out(ra_idx)
  );

  ccuod_reg_sel u_sel_b (
    .fld_in(instr_hw0_in[14:12]),
    .two_bit_in(two_b),
    .idx_out(rb_idx)
  );

  assign va = gr_r[ra_idx];
  assign vb = gr_r[rb_idx];
  assign vb_lo = vb[15:0];
  assign is_stor = dec_cls inside {ccuod_pkg::CLS_IC, ccuod_pkg::CLS_STC,
                                   ccuod_pkg::CLS_ICT, ccuod_pkg::CLS_STCT};
  assign is_ext = dec_cls inside {ccuod_pkg::CLS_IN, ccuod_pkg::CLS_OUT};
  assign is_adp = dec_cls inside {ccuod_pkg::CLS_IOH, ccuod_pkg::CLS_ADAPTER_REG_XFER_IMM};
  // the count forms carry no displacement field
  assign disp = (dec_cls inside {ccuod_pkg::CLS_IC, ccuod_pkg::CLS_STC}) ?
                instr_hw0_in[6:0] : 7'h00;
  assign ea_calc = vb[19:0] + {13'h0000, disp};
  assign rel_tgt = gr_r[0][19:0] + {13'h0000, instr_hw0_in[6:0]};
  assign imm20 = {instr_hw0_in[3:0], instr_hw1_in};
  assign dec_e = {instr_hw0_in[14:12], instr_hw0_in[6:3]};
  assign mask = {instr_hw0_in[13:12], instr_hw0_in[7]};
  // bit 0 is the most significant bit of the byte
  assign tst_byte = get_byte(va, instr_hw0_in[8]);
  assign bit_hit = tst_byte[3'h7 - mask];
  assign accept = (state_r == ccuod_pkg::ST_IDLE) && instr_ready_out && instr_valid_in;
  assign fin = (state_r == ccuod_pkg::ST_EXEC) && (cnt_r == '0) && !adp_req_out;

  // sequencing and minimum time
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= ccuod_pkg::ST_IDLE;
      cnt_r <= '0;
      instr_ready_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= fin;
      if (accept)
      begin
        state_r <= ccuod_pkg::ST_EXEC;
        cnt_r <= CNT_W'(min_pc * ccuod_pkg::CLK_PER_PCYC - 1);
        instr_ready_out <= 1'b0;
      end
      else if (fin)
      begin
        state_r <= ccuod_pkg::ST_IDLE;
        instr_ready_out <= ctrl_en_r;
      end
      else
      begin
        // the count holds while an adapter has not answered
        if (state_r == ccuod_pkg::ST_EXEC && !adp_req_out && cnt_r != '0)
          cnt_r <= cnt_r - 1'b1;
        instr_ready_out <= ctrl_en_r && state_r == ccuod_pkg::ST_IDLE;
      end
    end
  end

  // fields captured at acceptance
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      cls_r <= ccuod_pkg::CLS_NONE;
      ra_r <= 3'h0;
      rb_r <= 3'h0;
      na_r <= 1'b0;
      nb_r <= 1'b0;
      bit_r <= 1'b0;
      tgt_r <= 20'h00000;
      upd_r <= 1'b0;
    end
    else if (accept)
    begin
      cls_r <= dec_cls;
      ra_r <= ra_idx;
      rb_r <= rb_idx;
      na_r <= instr_hw0_in[8];
      nb_r <= instr_hw0_in[12];
      bit_r <= bit_hit;
      tgt_r <= (dec_cls == ccuod_pkg::CLS_BB) ? rel_tgt : imm20;
      upd_r <= upd_flag;
    end
  end

  // storage and external register requests, one cycle after acceptance
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      stor_req_out <= 1'b0;
      stor_wr_out <= 1'b0;
      stor_addr_out <= 20'h00000;
      stor_wdata_out <= 8'h00;
      ext_req_out <= 1'b0;
      ext_wr_out <= 1'b0;
      ext_addr_out <= 7'h00;
      ext_wdata_out <= 24'h000000;
      stor_cap_r <= 1'b0;
      ext_cap_r <= 1'b0;
      stor_data_r <= 8'h00;
      ext_data_r <= 24'h000000;
    end
    else
    begin
      stor_req_out <= accept && is_stor;
      stor_wr_out <= accept && (dec_cls inside {ccuod_pkg::CLS_STC, ccuod_pkg::CLS_STCT});
      ext_req_out <= accept && is_ext;
      ext_wr_out <= accept && dec_cls == ccuod_pkg::CLS_OUT;
      stor_cap_r <= stor_req_out && !stor_wr_out;
      ext_cap_r <= ext_req_out && !ext_wr_out;
      if (accept && is_stor)
      begin
        stor_addr_out <= ea_calc;
        stor_wdata_out <= get_byte(va, instr_hw0_in[8]);
      end
      if (accept && is_ext)
      begin
        ext_addr_out <= dec_e;
        ext_wdata_out <= va;
      end
      if (stor_cap_r)
        stor_data_r <= stor_rdata_in;
      if (ext_cap_r)
        ext_data_r <= ext_rdata_in;
    end
  end

  // adapter request holds until the adapter answers
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      adp_req_out <= 1'b0;
      adp_addr_out <= 16'h0000;
      adp_wdata_out <= 16'h0000;
      adp_data_r <= 16'h0000;
    end
    else if (accept && is_adp)
    begin
      adp_req_out <= 1'b1;
      adp_wdata_out <= va[15:0];
      if (dec_cls == ccuod_pkg::CLS_IOH)
        adp_addr_out <= vb_lo;
      else
        adp_addr_out <= instr_hw1_in;
    end
    else if (adp_req_out && adp_ack_in)
    begin
      adp_req_out <= 1'b0;
      adp_data_r <= adp_rdata_in;
    end
  end

  assign res_byte = (cls_r == ccuod_pkg::CLS_LCR) ? get_byte(gr_r[rb_r], nb_r) : stor_data_r;
  assign res_val = (cls_r inside {ccuod_pkg::CLS_IOH, ccuod_pkg::CLS_ADAPTER_REG_XFER_IMM}) ?
                   adp_data_r : {8'h00, res_byte};

  // general registers; a finishing instruction wins over software
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < 8; i++)
        gr_r[i] <= ccuod_pkg::GR_RST;
    end
    else
    begin
      if (sw_wr_in && !sw_addr_in[3])
        gr_r[sw_addr_in[2:0]] <= sw_wdata_in[23:0];
      if (fin)
      begin
        case (cls_r)
          ccuod_pkg::CLS_BAL:
          begin
            gr_r[ra_r] <= gr_r[0];
            gr_r[0] <= {4'h0, tgt_r};
          end
          ccuod_pkg::CLS_LA: gr_r[ra_r] <= {4'h0, tgt_r};
          ccuod_pkg::CLS_IN: gr_r[ra_r] <= ext_data_r;
          ccuod_pkg::CLS_IOH, ccuod_pkg::CLS_ADAPTER_REG_XFER_IMM:
            gr_r[ra_r] <= {gr_r[ra_r][23:16], adp_data_r};
          ccuod_pkg::CLS_IC, ccuod_pkg::CLS_LCR:
            gr_r[ra_r] <= put_byte(gr_r[ra_r], na_r, res_byte);
          ccuod_pkg::CLS_ICT:
          begin
            gr_r[ra_r] <= put_byte(gr_r[ra_r], na_r, res_byte);
            gr_r[rb_r] <= gr_r[rb_r] + 24'h000001;
          end
          ccuod_pkg::CLS_STCT: gr_r[rb_r] <= gr_r[rb_r] + 24'h000001;
          ccuod_pkg::CLS_BB:
            if (bit_r)
              gr_r[0] <= {4'h0, tgt_r};
          default: ;
        endcase
      end
    end
  end

  // condition latches and branch report
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      cond_c_out <= 1'b0;
      cond_z_out <= 1'b0;
      branch_out <= 1'b0;
      branch_addr_out <= 20'h00000;
    end
    else
    begin
      branch_out <= fin && (cls_r == ccuod_pkg::CLS_BAL ||
                            (cls_r == ccuod_pkg::CLS_BB && bit_r));
      if (fin)
        branch_addr_out <= tgt_r;
      if (fin && upd_r)
      begin
        cond_z_out <= res_val == 16'h0000;
        // character moves report even parity
        cond_c_out <= (cls_r == ccuod_pkg::CLS_LCR) ? ~^res_byte : res_val != 16'h0000;
      end
    end
  end

  // software port
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_en_r <= ccuod_pkg::CTRL_EN_RST;
      sw_rdata_out <= 32'h00000000;
    end
    else
    begin
      if (sw_wr_in && sw_addr_in == ccuod_pkg::REG_CTRL)
        ctrl_en_r <= sw_wdata_in[0];
      sw_rdata_out <= 32'h00000000;
      if (sw_rd_in)
      begin
        if (!sw_addr_in[3])
          sw_rdata_out <= {8'h00, gr_r[sw_addr_in[2:0]]};
        else if (sw_addr_in == ccuod_pkg::REG_CTRL)
          sw_rdata_out <= {31'h00000000, ctrl_en_r};
        else if (sw_addr_in == ccuod_pkg::REG_STATUS)
        begin
          sw_rdata_out[ccuod_pkg::ST_CLS_LSB +: 4] <= cls_r;
          sw_rdata_out[ccuod_pkg::ST_Z_BIT] <= cond_z_out;
          sw_rdata_out[ccuod_pkg::ST_C_BIT] <= cond_c_out;
          sw_rdata_out[ccuod_pkg::ST_BUSY_BIT] <= state_r == ccuod_pkg::ST_EXEC;
        end
      end
    end
  end

  // checking helpers
  logic [7:0] run_len_r;
  logic [7:0] min_len_r;
  logic [19:0] base_val;
  assign base_val = gr_r[rb_r][19:0];

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      run_len_r <= 8'h00;
      min_len_r <= 8'h00;
    end
    else if (accept)
    begin
      run_len_r <= 8'h00;
      min_len_r <= 8'(min_pc * ccuod_pkg::CLK_PER_PCYC);
    end
    else if (state_r == ccuod_pkg::ST_EXEC && run_len_r != 8'hff)
      run_len_r <= run_len_r + 8'h01;
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  min_time_a: assert property (done_out |-> run_len_r >= min_len_r)
    else $error("instruction finished before its minimum time");
  adp_stall_a: assert property (adp_req_out && !adp_ack_in |=> !done_out && !fin)
    else $error("instruction finished while the adapter was silent");
  latch_hold_a: assert property (fin && !(cls_r inside {ccuod_pkg::CLS_IOH,
      ccuod_pkg::CLS_ADAPTER_REG_XFER_IMM, ccuod_pkg::CLS_IC, ccuod_pkg::CLS_LCR})
      |=> $stable(cond_c_out) && $stable(cond_z_out))
    else $error("condition latches changed on a non-updating instruction");
  odd_reg_a: assert property (accept && two_a |=> ra_r[0])
    else $error("short register field reached an even register");
  pair_odd_a: assert property (accept && dec_cls == ccuod_pkg::CLS_LCR
      |=> ra_r[0] && rb_r[0])
    else $error("character move reached an even register");
  eff_addr_a: assert property (accept && is_stor
      |=> stor_req_out && stor_addr_out == $past(ea_calc))
    else $error("storage address is not base plus displacement");
  count_bump_a: assert property (fin && cls_r == ccuod_pkg::CLS_STCT
      |=> base_val == $past(base_val) + 20'h00001)
    else $error("base register not bumped after storage access");
  rel_branch_a: assert property (branch_out && cls_r == ccuod_pkg::CLS_BB
      |-> gr_r[0][19:0] == branch_addr_out)
    else $error("relative branch did not load register 0");
  ext_only_a: assert property (ext_req_out |-> !adp_req_out
      && ext_addr_out == $past(dec_e))
    else $error("controller register access went astray");
  adp_only_a: assert property ($rose(adp_req_out) |-> !ext_req_out
      && cls_r inside {ccuod_pkg::CLS_IOH, ccuod_pkg::CLS_ADAPTER_REG_XFER_IMM})
    else $error("adapter access from a non-adapter instruction");
  adp_addr_a: assert property (accept && dec_cls == ccuod_pkg::CLS_IOH
      |=> adp_req_out && adp_addr_out == $past(vb_lo))
    else $error("adapter address not taken from the second register");
  imm_addr_a: assert property (accept && dec_cls == ccuod_pkg::CLS_ADAPTER_REG_XFER_IMM
      |=> adp_addr_out == $past(instr_hw1_in))
    else $error("adapter address not taken from the second halfword");
  zero_lag_a: assert property (accept |=> state_r == ccuod_pkg::ST_EXEC
      && cls_r == $past(dec_cls))
    else $error("decode did not complete in the accepting cycle");

  cov_adp_c: cover property (adp_req_out ##1 !adp_req_out ##[1:60] done_out);
  cov_bal_c: cover property (branch_out && cls_r == ccuod_pkg::CLS_BAL);
  cov_ict_c: cover property (fin && cls_r == ccuod_pkg::CLS_ICT);
  cov_b2b_c: cover property (done_out ##[1:3] accept);

endmodule

// [verification/ccuod_far_model.sv]
`timescale 1ns/1ps
module ccuod_far_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] wait_in,
  input wire logic [15:0] resp_in,
  input wire logic adp_req_in,
  output logic adp_ack_out,
  output logic [15:0] adp_rdata_out,
  input wire logic stor_req_in,
  output logic [7:0] stor_rdata_out,
  input wire logic ext_req_in,
  input wire logic [6:0] ext_addr_in,
  output logic [23:0] ext_rdata_out
);
  logic [3:0] wait_r;
  // ack is one cycle; data outside it keeps toggling so stale reads show
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wait_r <= 4'h0;
      adp_ack_out <= 1'b0;
      adp_rdata_out <= 16'h5a5a;
    end
    else if (adp_req_in && !adp_ack_out && wait_r == wait_in)
    begin
      adp_ack_out <= 1'b1;
      adp_rdata_out <= resp_in;
    end
    else
    begin
      adp_ack_out <= 1'b0;
      adp_rdata_out <= ~adp_rdata_out;
      wait_r <= adp_req_in ? wait_r + 4'h1 : 4'h0;
    end
  end
  // read data valid only in the cycle after a request
  always_ff @(posedge clk_in)
  begin
    stor_rdata_out <= stor_req_in ? 8'h3c : ~stor_rdata_out;
    ext_rdata_out <= ext_req_in ? {17'h0, ext_addr_in} : ~ext_rdata_out;
  end
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk, rst, vld, wr, rd, rdy, done, br, cc, cz, sreq, swr, ereq, ewr, areq, ack;
  logic [15:0] hw0, hw1, aaddr, awd, ard, resp;
  logic [19:0] baddr, saddr;
  logic [7:0] swd, srd;
  logic [6:0] eaddr;
  logic [23:0] ewd, erd;
  logic [3:0] swa, wt;
  logic [31:0] sww, swr_d;
  int bad_count, cmp_count, n, held;
  logic [15:0] c_aaddr, c_awd;
  logic [6:0] c_eaddr;
  logic c_ewr, c_br;
  logic [19:0] c_saddr;
  logic [7:0] c_swd;
  logic [23:0] c_ewd;
  logic c_swr;
  ccuod_decoder dut (.sys_clk_in(clk), .sys_rst_in(rst), .instr_valid_in(vld),
    .instr_hw0_in(hw0), .instr_hw1_in(hw1), .instr_ready_out(rdy), .done_out(done),
    .branch_out(br), .branch_addr_out(baddr), .cond_c_out(cc), .cond_z_out(cz),
    .stor_req_out(sreq), .stor_wr_out(swr), .stor_addr_out(saddr), .stor_wdata_out(swd),
    .stor_rdata_in(srd), .ext_req_out(ereq), .ext_wr_out(ewr), .ext_addr_out(eaddr),
    .ext_wdata_out(ewd), .ext_rdata_in(erd), .adp_req_out(areq), .adp_addr_out(aaddr),
    .adp_wdata_out(awd), .adp_ack_in(ack), .adp_rdata_in(ard), .sw_addr_in(swa),
    .sw_wdata_in(sww), .sw_wr_in(wr), .sw_rd_in(rd), .sw_rdata_out(swr_d));
  ccuod_far_model far (.clk_in(clk), .rst_in(rst), .wait_in(wt), .resp_in(resp),
    .adp_req_in(areq), .adp_ack_out(ack), .adp_rdata_out(ard), .stor_req_in(sreq),
    .stor_rdata_out(srd), .ext_req_in(ereq), .ext_addr_in(eaddr), .ext_rdata_out(erd));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_cyc(string what, int exp, int got);
    cmp_count++;
    if (got != exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic sw_write(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    swa <= a;
    sww <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic sw_read(logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    swa <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = swr_d;
  endtask
  // issue one instruction, count cycles from accept to done
  task automatic run_ins(logic [15:0] h0, logic [15:0] h1);
    n = 0;
    held = 0;
    while (rdy !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk_val("ready", 32'h1, {31'h0, rdy});
    @(posedge clk);
    vld <= 1'b1;
    hw0 <= h0;
    hw1 <= h1;
    @(posedge clk);
    vld <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (areq === 1'b1)
      begin
        held++;
        c_aaddr = aaddr;
        c_awd = awd;
      end
      if (ereq === 1'b1)
      begin
        c_eaddr = eaddr;
        c_ewr = ewr;
        c_ewd = ewd;
      end
      if (sreq === 1'b1)
      begin
        c_saddr = saddr;
        c_swr = swr;
        c_swd = swd;
      end
      c_br = br;
    end
    while (done !== 1'b1 && n < 300);
    chk_val("done", 32'h1, {31'h0, done});
  endtask
  task automatic t_regs();
    logic [31:0] d;
    sw_read(4'h9, d);
    chk_val("ctrl reset", 32'h1, d);
    sw_read(4'ha, d);
    chk_val("unmapped", 32'h0, d);
    sw_write(4'h3, 32'h0012c0de);
    sw_write(4'h5, 32'h0000f00d);
    sw_read(4'h3, d);
    chk_val("gr3", 32'h0012c0de, d);
    sw_write(4'h9, 32'h0);
    repeat (2) @(negedge clk);
    chk_val("ready off", 32'h0, {31'h0, rdy});
    sw_write(4'h9, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_adapter();
    logic [31:0] d;
    wt <= 4'h3;
    resp <= 16'h00a5;
    run_ins(16'h0170, 16'hbeef);
    chk_val("imm adp addr", 32'hbeef, {16'h0, c_aaddr});
    // three wait cycles in the far model keep the request up for five edges
    chk_cyc("imm held", 5, held);
    chk_cyc("imm cycles", ccuod_pkg::MIN_ADAPTER_REG_XFER_IMM * ccuod_pkg::CLK_PER_PCYC + 6, n);
    chk_val("imm cz", 32'h2, {30'h0, cc, cz});
    sw_read(4'h1, d);
    chk_val("imm gr1", 32'h00a5, {16'h0, d[15:0]});
    wt <= 4'h0;
    resp <= 16'h0000;
    run_ins(16'h3550, 16'h0000);
    chk_val("reg adp addr", 32'hc0de, {16'h0, c_aaddr});
    chk_val("reg adp wdata", 32'hf00d, {16'h0, c_awd});
    chk_cyc("reg held", 2, held);
    chk_cyc("reg cycles", ccuod_pkg::MIN_IOH * ccuod_pkg::CLK_PER_PCYC + 3, n);
    chk_val("reg cz", 32'h1, {30'h0, cc, cz});
    $display("test adapter done");
  endtask
  task automatic t_addr20();
    logic [31:0] d;
    run_ins(16'hba0a, 16'h5c3e);
    chk_cyc("la cycles", ccuod_pkg::MIN_LA * ccuod_pkg::CLK_PER_PCYC + 1, n);
    sw_read(4'h2, d);
    chk_val("la gr2", 32'h000a5c3e, d);
    chk_val("la cz", 32'h1, {30'h0, cc, cz});
    run_ins(16'hbb43, 16'h1234);
    chk_val("bal taken", 32'h1, {31'h0, c_br});
    chk_val("bal target", 32'h31234, {12'h0, baddr});
    chk_cyc("bal cycles", ccuod_pkg::MIN_BAL * ccuod_pkg::CLK_PER_PCYC + 1, n);
    $display("test addr20 done");
  endtask
  task automatic t_ext();
    logic [31:0] d;
    run_ins(16'h70f8, 16'h0000);
    chk_val("in addr", 32'h7f, {25'h0, c_eaddr});
    chk_val("in dir", 32'h0, {31'h0, c_ewr});
    chk_val("in no adp", 32'h0, held);
    sw_read(4'h0, d);
    chk_val("in gr0", 32'h7f, d);
    run_ins(16'h0184, 16'h0000);
    chk_val("out addr", 32'h0, {25'h0, c_eaddr});
    chk_val("out dir", 32'h1, {31'h0, c_ewr});
    chk_val("out wdata", 32'ha5, {8'h0, c_ewd});
    $display("test ext done");
  endtask
  task automatic t_stor();
    logic [31:0] d;
    sw_write(4'h6, 32'h00001000);
    run_ins(16'h6d05, 16'h0000);
    chk_val("ic addr", 32'h1005, {12'h0, c_saddr});
    chk_val("ic dir", 32'h0, {31'h0, c_swr});
    chk_cyc("ic cycles", ccuod_pkg::MIN_IC * ccuod_pkg::CLK_PER_PCYC + 1, n);
    chk_val("ic cz", 32'h2, {30'h0, cc, cz});
    sw_read(4'h5, d);
    chk_val("ic gr5", 32'h3c, d);
    run_ins(16'h6520, 16'h0000);
    chk_val("stct addr", 32'h1000, {12'h0, c_saddr});
    chk_val("stct data", 32'h13c, {23'h0, c_swr, c_swd});
    chk_cyc("stct cycles", ccuod_pkg::MIN_STCT * ccuod_pkg::CLK_PER_PCYC + 1, n);
    sw_read(4'h6, d);
    chk_val("stct base", 32'h1001, d);
    run_ins(16'hdd10, 16'h0000);
    chk_val("bb taken", 32'h1, {31'h0, c_br});
    chk_val("bb target", 32'h8f, {12'h0, baddr});
    chk_cyc("bb cycles", ccuod_pkg::MIN_BB * ccuod_pkg::CLK_PER_PCYC + 1, n);
    run_ins(16'h5008, 16'h0000);
    sw_read(4'h1, d);
    chk_val("lcr gr1", 32'h3ca5, d);
    sw_read(4'h8, d);
    chk_val("lcr status", 32'h2b, d);
    $display("test stor done");
  endtask
  initial
  begin
    #(40 * 5000);
    bad_count++;
    end_of_test();
  end
  initial
  begin
    rst = 1'b1;
    {vld, wr, rd} = 3'h0;
    hw0 = 16'h0;
    hw1 = 16'h0;
    swa = 4'h0;
    sww = 32'h0;
    wt = 4'h0;
    resp = 16'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_adapter();
    t_addr20();
    t_ext();
    t_stor();
    end_of_test();
  end
endmodule
